// ==== hw/otp_spi_device.sv ====
// Purpose: OTP security register array with its serial command decoder.
// Assumes: Mode 0 link, slow against clk_in; all link pins synchronised.
// Notes:   Array content is reloaded at reset to stand in for retention.
`timescale 1ns/1ns
`default_nettype none
module otp_spi_device #(
   parameter int PROG_CYCLES = otp_pkg::OTP_PROGRAM_CYCLES // Program time
) (
   input wire logic clk_in, // 20 MHz clock
   input wire logic srst_in, // Sync reset, active high
   spi_link_if.device link, // Serial link
   output logic [7:0] status1_out, // Status one: busy, latch
   output logic [7:0] status2_out // Status two: lock flags
);
   import otp_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0] cs_sync; // [0] first flop, [1] second, [2] previous
      logic [2:0] sck_sync;
      logic [1:0] mosi_sync;
      dev_state_t state;
      logic prog_cmd;
      logic stat2;
      logic [1:0] addr_bytes;
      logic [2:0] rx_bits;
      logic [2:0] tx_bits;
      logic [7:0] rx_shift;
      logic [7:0] tx_shift;
      logic [8:0] addr;
      logic got_data;
      logic write_enable_latch;
      logic operation_in_progress_flag;
      logic [31:0] timer;
      logic [1:0] prog_reg;
      logic [2:0] otp_lock_flags;
      logic miso;
      logic miso_oe;
      logic [OTP_REG_BYTES-1:0][7:0] pbuf;
      logic [OTP_BYTES-1:0][7:0] mem;
   } dev_regs_t;

   dev_regs_t r_reg;
   dev_regs_t r_next;
   logic sck_rise;
   logic sck_fall;
   logic cs_rise;
   logic cs_low;
   logic [7:0] rx_byte;
   logic [7:0] ld_byte;
   logic [7:0] sr1;
   logic [7:0] sr2;
   logic tgt_locked;

   // ----------------------------------------------------------------
   // Edge detection on the synchronised pins
   // ----------------------------------------------------------------
   assign sck_rise = r_reg.sck_sync[1] & ~r_reg.sck_sync[2];
   assign sck_fall = ~r_reg.sck_sync[1] & r_reg.sck_sync[2];
   assign cs_rise = r_reg.cs_sync[1] & ~r_reg.cs_sync[2];
   assign cs_low = ~r_reg.cs_sync[1];
   assign rx_byte = {r_reg.rx_shift[6:0], r_reg.mosi_sync[1]};

   // Status bytes, rebuilt every cycle so polling sees live values
   always_comb begin
      sr1 = 8'h00;
      sr1[SR1_BUSY_BIT] = r_reg.operation_in_progress_flag;
      sr1[SR1_WEL_BIT] = r_reg.write_enable_latch;
      sr2 = 8'h00;
      sr2[SR2_LOCK_LSB +: 3] = r_reg.otp_lock_flags;
   end

   // Register zero counts as locked whatever its top byte holds
   always_comb begin
      if (r_reg.addr[8:7] == 2'b00) begin
         tgt_locked = 1'b1;
      end else begin
         tgt_locked = r_reg.otp_lock_flags[r_reg.addr[8:7] - 2'b01];
      end
   end

   // Next outgoing byte: a status byte or the addressed array byte
   assign ld_byte = (r_reg.state == ST_STAT) ? (r_reg.stat2 ? sr2 : sr1)
                                             : r_reg.mem[r_reg.addr];

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      r_next = r_reg;
      r_next.cs_sync = {r_reg.cs_sync[1:0], link.cs_n};
      r_next.sck_sync = {r_reg.sck_sync[1:0], link.sck};
      r_next.mosi_sync = {r_reg.mosi_sync[0], link.mosi};

      // Self-timed program cycle; bits only ever go from one to zero
      if (r_reg.operation_in_progress_flag) begin
         r_next.timer = r_reg.timer - 32'd1;
         if (r_reg.timer <= 32'd1) begin
            r_next.operation_in_progress_flag = 1'b0;
            for (int i = 0; i < OTP_REG_BYTES; i++) begin
               r_next.mem[{r_reg.prog_reg, 7'(i)}] =
                  r_reg.mem[{r_reg.prog_reg, 7'(i)}] & r_reg.pbuf[i];
            end
         end
      end

      if (cs_rise) begin
         // Frame end: release the output and judge a pending program
         r_next.state = ST_IDLE;
         r_next.miso_oe = 1'b0;
         r_next.prog_cmd = 1'b0;
         if (r_reg.prog_cmd) begin
            r_next.write_enable_latch = 1'b0;
            if (r_reg.state == ST_PDATA && r_reg.rx_bits == 3'd0 &&
                !tgt_locked && r_reg.got_data) begin
               r_next.operation_in_progress_flag = 1'b1;
               r_next.timer = 32'(PROG_CYCLES);
               r_next.prog_reg = r_reg.addr[8:7];
            end // else aborted
         end
      end else if (cs_low) begin
         if (r_reg.state == ST_IDLE) begin
            // Frame start
            r_next.state = ST_CMD;
            r_next.rx_bits = 3'd0;
            r_next.tx_bits = 3'd0;
            r_next.addr_bytes = 2'd0;
            r_next.got_data = 1'b0;
         end else if (sck_rise) begin
            // Input sampled on the rising edge, MSB first
            r_next.rx_shift = rx_byte;
            r_next.rx_bits = r_reg.rx_bits + 3'd1;
            if (r_reg.rx_bits == 3'd7) begin
               case (r_reg.state)
                  ST_CMD: begin
                     r_next.state = ST_IGNORE;
                     if (rx_byte == CMD_READ_OTP && !r_reg.operation_in_progress_flag) begin
                        r_next.state = ST_ADDR;
                     end else if (rx_byte == CMD_PROG_OTP && r_reg.write_enable_latch &&
                                  !r_reg.operation_in_progress_flag) begin
                        r_next.state = ST_ADDR;
                        r_next.prog_cmd = 1'b1;
                        for (int i = 0; i < OTP_REG_BYTES; i++) begin
                           r_next.pbuf[i] = OTP_ERASED;
                        end
                     end else if (rx_byte == CMD_WRITE_ENABLE &&
                                  !r_reg.operation_in_progress_flag) begin
                        r_next.write_enable_latch = 1'b1;
                     end else if (rx_byte == CMD_READ_STATUS1 ||
                                  rx_byte == CMD_READ_STATUS2) begin
                        r_next.state = ST_STAT;
                        r_next.stat2 = (rx_byte == CMD_READ_STATUS2);
                        r_next.miso_oe = 1'b1;
                     end
                  end
                  ST_ADDR: begin
                     // Only the low nine address bits are kept
                     r_next.addr = {r_reg.addr[0], rx_byte};
                     r_next.addr_bytes = r_reg.addr_bytes + 2'd1;
                     if (r_reg.addr_bytes == 2'd2) begin
                        r_next.state = r_reg.prog_cmd ? ST_PDATA : ST_DUMMY;
                     end
                  end
                  ST_DUMMY: begin
                     r_next.state = ST_RDATA;
                     r_next.miso_oe = 1'b1;
                  end
                  ST_PDATA: begin
                     // Byte index wraps inside the chosen register
                     r_next.pbuf[r_reg.addr[6:0]] = rx_byte;
                     r_next.addr[6:0] = r_reg.addr[6:0] + 7'd1;
                     r_next.got_data = 1'b1;
                  end
                  default: begin
                  end
               endcase
            end
         end else if (sck_fall && (r_reg.state == ST_RDATA || r_reg.state == ST_STAT)) begin
            // Output changes on the falling edge, MSB first
            r_next.tx_bits = r_reg.tx_bits + 3'd1;
            if (r_reg.tx_bits == 3'd0) begin
               r_next.tx_shift = ld_byte;
               if (r_reg.state == ST_RDATA) begin
                  r_next.addr = r_reg.addr + 9'd1;
               end
            end else begin
               r_next.tx_shift = {r_reg.tx_shift[6:0], 1'b0};
            end
            r_next.miso = r_next.tx_shift[7];
         end
      end

      // Lock flags follow the top byte of each user register
      for (int k = 1; k < 4; k++) begin
         r_next.otp_lock_flags[k-1] =
            (r_next.mem[k*OTP_REG_BYTES + OTP_REG_BYTES - 1] != OTP_ERASED);
      end

      // Sync reset: pins idle, factory content in register zero
      if (srst_in) begin
         r_next = '0;
         r_next.cs_sync = 3'b111;
         r_next.state = ST_IDLE;
         for (int i = 0; i < OTP_REG_BYTES; i++) begin
            r_next.pbuf[i] = OTP_ERASED;
         end
         for (int i = 0; i < OTP_BYTES; i++) begin
            r_next.mem[i] = (i < OTP_REG_BYTES) ? (8'(i) ^ FACTORY_SEED) : OTP_ERASED;
         end
         r_next.otp_lock_flags = 3'b000;
      end
   end

   // ----------------------------------------------------------------
   // Registers and outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      r_reg <= r_next;
   end

   // Outputs straight from flops
   assign link.miso_drv = r_reg.miso;
   assign link.miso_oe = r_reg.miso_oe;
   assign status1_out = {6'h00, r_reg.write_enable_latch, r_reg.operation_in_progress_flag};
   assign status2_out = {2'b00, r_reg.otp_lock_flags, 3'b000};
endmodule // otp_spi_device
`default_nettype wire

// ==== hw/otp_pkg.sv ====
// Purpose: Shared constants and types for the OTP security register link.
// Assumes: One 20 MHz clock; SPI mode 0; MSB first on every byte.
// Notes:   Summary of operation
// Summary of operation
// - Only address bits 8..0 select a byte
// - Bits 6..0 byte, bits 8..7 register
// - Register zero always locked, never programmed
// - Busy flag shown during programming
// - Host polls status rather than waiting
// - Write enable latch cleared before program ends
// - Programmed top byte locks user register
// - Lower bytes programmable bitwise, repeatedly, unlocked
// - Status two bits 5..3 show locks
// - Release off byte boundary aborts programming
// - Incomplete address or data clears latch
// - Locked target register aborts programming
// - Command, address in; data out, one line
// - Host sends read command, eight clocks
// - Host sends 24 address bits, A23 first
// - Dummy byte precedes any array read data; status bytes follow the command directly
// - Bytes out MSB first while selected
// - Read address runs across register boundaries
// - Host sets latch before program command
// - Host sends program command, address, data
// - Buffered bytes written once the program time after chip select release ends
package otp_pkg;
   // ----------------------------------------------------------------
   // Commands
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_READ_OTP = 8'h4b;
   localparam logic [7:0] CMD_PROG_OTP = 8'h9b;
   localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] CMD_READ_STATUS1 = 8'h05;
   localparam logic [7:0] CMD_READ_STATUS2 = 8'h35;
   // ----------------------------------------------------------------
   // Array shape and fields
   // ----------------------------------------------------------------
   localparam int OTP_REG_BYTES = 128;
   localparam int OTP_BYTES = 512;
   localparam logic [7:0] OTP_ERASED = 8'hff;
   localparam logic [7:0] FACTORY_SEED = 8'h5a; // Arbitrary factory pattern
   localparam int SR1_BUSY_BIT = 0;
   localparam int SR1_WEL_BIT = 1;
   localparam int SR2_LOCK_LSB = 3;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_FREQ_MHZ = 20;
   localparam int OTP_PROGRAM_TIME_US = 500;
   localparam int OTP_PROGRAM_CYCLES = OTP_PROGRAM_TIME_US * CLK_FREQ_MHZ;
   localparam logic [3:0] SCK_HALF_CYCLES = 4'h8;
   // ----------------------------------------------------------------
   // Host register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [3:0] HOST_TX_OFS = 4'h0;
   localparam logic [3:0] HOST_RX_OFS = 4'h4;
   localparam logic [3:0] HOST_CTRL_OFS = 4'h8;
   localparam int HOST_CTRL_RELEASE_BIT = 0;
   // ----------------------------------------------------------------
   // State encodings
   // ----------------------------------------------------------------
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01, ST_CMD = 8'h02, ST_ADDR = 8'h04, ST_DUMMY = 8'h08,
      ST_RDATA = 8'h10, ST_PDATA = 8'h20, ST_STAT = 8'h40, ST_IGNORE = 8'h80
   } dev_state_t;
   typedef enum logic [2:0] {
      H_IDLE = 3'h1, H_SHIFT = 3'h2, H_STOP = 3'h4
   } host_state_t;
endpackage

// ==== hw/spi_link_if.sv ====
// Purpose: Serial link between the OTP host and the OTP device.
// Assumes: Device output is released when not driven; line idles high.
// Notes:   The resolved data-out line is formed here from the enable.
`timescale 1ns/1ns
`default_nettype none
interface spi_link_if;
   logic cs_n;
   logic sck;
   logic mosi;
   logic miso_drv;
   logic miso_oe;
   logic miso_line;
   // Released line reads as a pull-up
   assign miso_line = miso_oe ? miso_drv : 1'b1;
   modport host (output cs_n, output sck, output mosi, input miso_line);
   modport device (input cs_n, input sck, input mosi, output miso_drv, output miso_oe);
endinterface
`default_nettype wire

// ==== hw/otp_spi_host.sv ====
// Purpose: Byte-level serial master for the OTP device, driven over Avalon-MM.
// Assumes: Software sequences command, address, dummy and data bytes itself.
// Notes:   Waitrequest stalls a request to the TX, RX or control offset until the shifter is idle.
`timescale 1ns/1ns
`default_nettype none
module otp_spi_host (
   input wire logic clk_in, // 20 MHz clock
   input wire logic srst_in, // Sync reset, active high
   spi_link_if.host link, // Serial link
   input wire logic [3:0] address_in, // Avalon byte address
   input wire logic read_in, // Avalon read
   input wire logic write_in, // Avalon write
   input wire logic [31:0] writedata_in, // Avalon write data
   output logic [31:0] readdata_out, // Avalon read data
   output logic waitrequest_out // Avalon waitrequest
);
   import otp_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      host_state_t state;
      logic [3:0] div;
      logic [2:0] bits;
      logic [7:0] tx;
      logic [7:0] rx;
      logic cs_n;
      logic sck;
      logic mosi;
      logic [1:0] miso_sync; // [0] first flop, read only by [1]
      logic wait_r;
      logic [31:0] rdata;
   } host_regs_t;

   host_regs_t r_reg;
   host_regs_t r_next;
   logic req;
   logic idle;

   assign req = read_in | write_in;
   assign idle = (r_reg.state == H_IDLE);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      r_next = r_reg;
      r_next.miso_sync = {r_reg.miso_sync[0], link.miso_line};
      r_next.wait_r = 1'b1;

      // Divided link clock; half period of SCK_HALF_CYCLES
      if (r_reg.state != H_IDLE) begin
         r_next.div = r_reg.div + 4'd1;
      end
      if (r_reg.state == H_SHIFT && r_reg.div == SCK_HALF_CYCLES - 4'd1) begin
         r_next.div = 4'd0;
         if (!r_reg.sck) begin
            r_next.sck = 1'b1;
            r_next.rx = {r_reg.rx[6:0], r_reg.miso_sync[1]};
         end else begin
            r_next.sck = 1'b0;
            r_next.tx = {r_reg.tx[6:0], 1'b0};
            r_next.mosi = r_reg.tx[6];
            r_next.bits = r_reg.bits + 3'd1;
            if (r_reg.bits == 3'd7) begin
               r_next.state = H_IDLE; // Whole bytes only
            end
         end
      end
      // Release: wait a half period, raise select, hold it a half period
      if (r_reg.state == H_STOP && r_reg.div == SCK_HALF_CYCLES - 4'd1) begin
         r_next.div = 4'd0;
         if (!r_reg.cs_n) begin
            r_next.cs_n = 1'b1;
         end else begin
            r_next.state = H_IDLE;
         end
      end

      // Bus slave: acknowledge TX, RX and control once idle, other offsets at once; action at the acknowledged edge
      if (req && r_reg.wait_r && (idle || !(address_in == HOST_TX_OFS ||
          address_in == HOST_RX_OFS || address_in == HOST_CTRL_OFS))) begin
         r_next.wait_r = 1'b0;
         case (address_in)
            HOST_TX_OFS: r_next.rdata = {24'h000000, r_reg.tx};
            HOST_RX_OFS: r_next.rdata = {24'h000000, r_reg.rx};
            HOST_CTRL_OFS: r_next.rdata = {30'h0, ~r_reg.cs_n, ~idle};
            default: r_next.rdata = 32'h00000000;
         endcase
      end
      if (write_in && !r_reg.wait_r) begin
         if (address_in == HOST_TX_OFS) begin
            r_next.state = H_SHIFT;
            r_next.cs_n = 1'b0;
            r_next.tx = writedata_in[7:0];
            r_next.mosi = writedata_in[7];
            r_next.bits = 3'd0;
            r_next.div = 4'd0;
         end else if (address_in == HOST_CTRL_OFS &&
                      writedata_in[HOST_CTRL_RELEASE_BIT] && !r_reg.cs_n) begin
            r_next.state = H_STOP;
            r_next.div = 4'd0;
         end
      end

      if (srst_in) begin
         r_next = '0;
         r_next.state = H_IDLE;
         r_next.cs_n = 1'b1;
         r_next.miso_sync = 2'b11;
         r_next.wait_r = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Registers and outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      r_reg <= r_next;
   end

   assign link.cs_n = r_reg.cs_n;
   assign link.sck = r_reg.sck;
   assign link.mosi = r_reg.mosi;
   assign readdata_out = r_reg.rdata;
   assign waitrequest_out = r_reg.wait_r;
endmodule // otp_spi_host
`default_nettype wire

// ==== tb/otp_link_assertions.sv ====
// Purpose: Link checks between the OTP host and device ends.
// Assumes: Mode 0 link, link clock slow against clk_in.
// Notes:   Bit counter restarts while select is high.
`timescale 1ns/1ns
`default_nettype none
module otp_link_assertions (
   input wire logic clk_in, // 20 MHz clock
   input wire logic srst_in, // Sync reset, active high
   input wire logic cs_n_in, // Select, active low
   input wire logic sck_in, // Link clock
   input wire logic mosi_in, // Host data
   input wire logic miso_drv_in, // Device data
   input wire logic miso_oe_in, // Device drive enable
   input wire logic miso_line_in // Resolved device line
);
   import otp_pkg::*;
   logic sck_q_reg;
   logic [15:0] bits_reg;
   logic [7:0] shift_reg;
   logic [7:0] cmd_reg;
   logic rise;
   // Raw pin edge, so the count leads the device's synchroniser
   assign rise = sck_in & ~sck_q_reg;
   // Frame bit count and first byte capture
   always_ff @(posedge clk_in) begin
      sck_q_reg <= srst_in ? 1'b0 : sck_in;
      if (srst_in || cs_n_in) begin
         bits_reg <= 16'h0000;
      end else if (rise) begin
         bits_reg <= bits_reg + 16'h0001;
      end
      if (rise) begin
         shift_reg <= {shift_reg[6:0], mosi_in};
      end
      if (rise && bits_reg == 16'h0007) begin
         cmd_reg <= {shift_reg[6:0], mosi_in};
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);
   // --------------------------------------------------------------
   // Properties
   // --------------------------------------------------------------
   a_sck_half_period: assert property ($changed(sck_in) |=> $stable(sck_in) [*7])
      else $error("link clock half period too short");
   a_sck_idle_low: assert property (cs_n_in |-> !sck_in)
      else $error("link clock high outside a frame");
   a_mosi_at_rise: assert property ($rose(sck_in) |-> $stable(mosi_in))
      else $error("host data moved at a link clock rise");
   a_byte_frame_end: assert property ($rose(cs_n_in) |-> bits_reg[2:0] == 3'h0)
      else $error("frame ended off a byte boundary");
   a_no_early_data: assert property (!cs_n_in && bits_reg != 16'h0000 &&
      (bits_reg < 16'h0008 || (cmd_reg == CMD_READ_OTP && bits_reg < 16'h0028))
      |-> !miso_oe_in)
      else $error("device drove before the dummy byte ended");
   a_release_drops_oe: assert property ($rose(cs_n_in) |-> ##[1:8] !miso_oe_in)
      else $error("device kept driving after deselect");
   a_idle_released: assert property (cs_n_in [*8] |-> !miso_oe_in && miso_line_in)
      else $error("device line not released while idle");
   a_miso_changes_low: assert property (miso_oe_in && $past(miso_oe_in) &&
      $changed(miso_drv_in) |-> !sck_in)
      else $error("device data changed while link clock high");
endmodule // otp_link_assertions
`default_nettype wire

// ==== tb/otp_security_register_access_tb.sv ====
// Purpose: Bench joining OTP host and device over the serial link.
// Assumes: Short program time through PROG_CYCLES.
// Notes:   Array reloads at reset, so runs start from factory content.
`timescale 1ns/1ns
`default_nettype none
module otp_security_register_access_tb;
   import otp_pkg::*;
   typedef struct packed {logic [23:0] addr; logic [7:0] b0; logic [7:0] b1;} rd_row_t;
   logic clk_in, srst_in, av_read, av_write, av_wait, mon_sck_q;
   logic [3:0] av_address;
   logic [31:0] av_wdata, av_rdata, av_word;
   logic [7:0] status1, status2, mon_shift, rb0, rb1;
   int num_errors, checks_done;
   rd_row_t rows [3];
   spi_link_if i_spi_link_if ();
   otp_spi_host i_otp_spi_host (.clk_in(clk_in), .srst_in(srst_in), .link(i_spi_link_if.host),
      .address_in(av_address), .read_in(av_read), .write_in(av_write),
      .writedata_in(av_wdata), .readdata_out(av_rdata), .waitrequest_out(av_wait));
   otp_spi_device #(.PROG_CYCLES(20)) i_otp_spi_device (.clk_in(clk_in), .srst_in(srst_in),
      .link(i_spi_link_if.device), .status1_out(status1), .status2_out(status2));
   otp_link_assertions i_otp_link_assertions (.clk_in(clk_in), .srst_in(srst_in),
      .cs_n_in(i_spi_link_if.cs_n), .sck_in(i_spi_link_if.sck),
      .mosi_in(i_spi_link_if.mosi), .miso_drv_in(i_spi_link_if.miso_drv),
      .miso_oe_in(i_spi_link_if.miso_oe), .miso_line_in(i_spi_link_if.miso_line));
   // --------------------------------------------------------------
   // Clock, wire monitor and tasks
   // --------------------------------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   // Host data as seen on the wire, MSB first
   always @(posedge clk_in) begin
      mon_sck_q <= i_spi_link_if.sck;
      if (i_spi_link_if.sck && !mon_sck_q) begin
         mon_shift <= {mon_shift[6:0], i_spi_link_if.mosi};
      end
   end
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // One Avalon access; held until waitrequest is seen low
   task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d,
         output logic [31:0] r);
      int n;
      av_address <= a;
      av_write <= wr;
      av_read <= ~wr;
      av_wdata <= d;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (av_wait !== 1'b0 && n < 4000);
      r = av_rdata;
      if (n >= 4000) begin
         num_errors++;
         end_sim();
      end
      av_write <= 1'b0;
      av_read <= 1'b0;
      @(posedge clk_in);
   endtask
   // One link byte: the RX read stalls until the shift is over
   task automatic xb(input logic [7:0] b, output logic [7:0] r);
      logic [31:0] w;
      av(1'b1, HOST_TX_OFS, {24'h000000, b}, w);
      av(1'b0, HOST_RX_OFS, 32'h00000000, w);
      r = w[7:0];
   endtask
   task automatic rel();
      logic [31:0] w;
      av(1'b1, HOST_CTRL_OFS, 32'h00000001, w);
   endtask
   task automatic hdr(input logic [7:0] cmd, input logic [23:0] a);
      logic [7:0] r;
      xb(cmd, r);
      xb(a[23:16], r);
      xb(a[15:8], r);
      xb(a[7:0], r);
   endtask
   task automatic rd2(input logic [23:0] a);
      logic [7:0] r;
      hdr(CMD_READ_OTP, a);
      chk("wire_addr", mon_shift, a[7:0]);
      xb(8'h00, r);
      xb(8'h00, rb0);
      xb(8'h00, rb1);
      rel();
   endtask
   task automatic wen();
      logic [7:0] r;
      xb(CMD_WRITE_ENABLE, r);
      rel();
   endtask
   // Status byte over the link: command, one byte out, release
   task automatic rds(input logic [7:0] cmd, output logic [7:0] v);
      logic [7:0] r;
      xb(cmd, r);
      xb(8'h00, v);
      rel();
   endtask
   // Program one byte, then poll busy with a bound
   task automatic prog(input logic [23:0] a, input logic [7:0] d, input logic [7:0] busy_exp);
      logic [7:0] r;
      logic [7:0] seen;
      wen();
      chk("wire_cmd", mon_shift, CMD_WRITE_ENABLE);
      chk("status1_wel", status1, 8'h02);
      hdr(CMD_PROG_OTP, a);
      xb(d, r);
      rel();
      seen = 8'h00;
      for (int n = 0; n < 300 && !(seen[0] && status1[0] === 1'b0); n++) begin
         @(posedge clk_in);
         if (status1[0] === 1'b1) begin
            seen = 8'h01;
         end
      end
      chk("busy_seen", seen, busy_exp);
      chk("status1_done", status1, 8'h00);
   endtask
   task automatic end_sim();
      if (num_errors == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // --------------------------------------------------------------
   // Tests
   // --------------------------------------------------------------
   initial begin
      srst_in = 1'b1;
      av_address = 4'h0;
      av_read = 1'b0;
      av_write = 1'b0;
      av_wdata = 32'h00000000;
      num_errors = 0;
      checks_done = 0;
      rows[0] = '{24'hfe007f, 8'h7f ^ FACTORY_SEED, OTP_ERASED};
      rows[1] = '{24'h3a0000, FACTORY_SEED, 8'h01 ^ FACTORY_SEED};
      rows[2] = '{24'h0001ff, OTP_ERASED, FACTORY_SEED};
      repeat (10) @(posedge clk_in);
      srst_in <= 1'b0;
      @(posedge clk_in);
      foreach (rows[i]) begin
         rd2(rows[i].addr);
         chk("read_b0", rb0, rows[i].b0);
         chk("read_b1", rb1, rows[i].b1);
      end
      // Repeated programming only clears bits
      prog(24'h000080, 8'ha5, 8'h01);
      prog(24'h000080, 8'h3c, 8'h01);
      rd2(24'h000080);
      chk("prog_and", rb0, 8'ha5 & 8'h3c);
      chk("prog_next", rb1, OTP_ERASED);
      prog(24'h000010, 8'h00, 8'h00);
      rd2(24'h000010);
      chk("reg0_kept", rb0, 8'h10 ^ FACTORY_SEED);
      prog(24'h0000ff, 8'h7f, 8'h01);
      chk("lock_flags", status2, 8'h08);
      rds(CMD_READ_STATUS2, rb0);
      chk("link_sr2", rb0, 8'h08);
      prog(24'h000081, 8'h00, 8'h00);
      // Address cut short: latch cleared, nothing written
      wen();
      rds(CMD_READ_STATUS1, rb0);
      chk("link_sr1", rb0, 8'h02);
      xb(CMD_PROG_OTP, rb0);
      xb(8'h00, rb0);
      av(1'b0, HOST_CTRL_OFS, 32'h00000000, av_word);
      chk("ctrl_cs", av_word[7:0], 8'h02);
      rel();
      rd2(24'h000081);
      chk("locked_kept", rb0, OTP_ERASED);
      chk("abort_wel", status1, 8'h00);
      // Second reset: idle link, flags cleared
      srst_in <= 1'b1;
      repeat (10) @(posedge clk_in);
      srst_in <= 1'b0;
      @(posedge clk_in);
      chk("status2_rst", status2, 8'h00);
      chk("cs_idle", {7'h00, i_spi_link_if.cs_n}, 8'h01);
      chk("miso_idle", {7'h00, i_spi_link_if.miso_line}, 8'h01);
      end_sim();
   end
   // Watchdog well beyond the expected run of some 12000 cycles
   initial begin
      #3000000;
      num_errors++;
      end_sim();
   end
endmodule // otp_security_register_access_tb
`default_nettype wire
